// ### design/sac_pkg.sv
// shared constants, pin carrier and state type of the converter control
package sac_pkg;
   localparam int DATA_W        = 16;
   localparam int FIFO_DEPTH    = 32;
   localparam int LEVEL_W       = $clog2(FIFO_DEPTH) + 1;
   localparam int CNT_W         = 16;
   localparam int CLK_PERIOD_NS = 4;
   localparam int SCLK_QTR_CYC  = 4;
   localparam int SERIAL_DATA_OUT_BIT     = 8;
   localparam int SCLK_BIT      = 9;
   localparam int FRAME_BIT     = 10;
   localparam int ERR_BIT       = 11;
   localparam int UPPER_LSB     = 12;
   localparam logic [3:0] LAST_BIT  = 4'hf;
   localparam logic [1:0] PH_RISE   = 2'h1;
   localparam logic [1:0] PH_HIGH   = 2'h2;
   localparam logic [1:0] PH_CHANGE = 2'h3;

   typedef struct packed {
      logic resetHi;
      logic powerDown;
      logic startN;
      logic csN;
      logic rdN;
      logic serSel;
      logic extClk;
      logic sclkInv;
      logic framePol;
      logic readMode;
      logic sclk;
   } sac_pins_t;

   localparam int PIN_W = $bits(sac_pins_t);
   // strobes and selects idle high
   localparam logic [PIN_W-1:0] PIN_RST = 11'h1c0;

   typedef enum logic [2:0] {
      ST_ACQUIRE,
      ST_WAIT_START,
      ST_CONVERT,
      ST_LOAD,
      ST_POWER_DOWN
   } sac_state_t;
endpackage

// ### design/sac_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module sac_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            q[i] <= RST_VAL[i];
         end else if (s2_r[i] == s3_r[i]) begin
            q[i] <= s3_r[i];
         end
      end
   end
endmodule

// ### design/sac_fifo.sv
// result buffer with valid/ready on both sides
`timescale 1ns/1ns
module sac_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 32,
   parameter int LW    = $clog2(DEPTH) + 1
)(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          inValid,
   output logic               inReady,
   input  wire logic [W-1:0]  inData,
   output logic               outValid,
   input  wire logic          outReady,
   output logic      [W-1:0]  outData,
   output logic      [LW-1:0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [LW-1:0] level_r;
   logic          push;
   logic          pop;

   assign inReady  = (level_r != LW'(DEPTH));
   assign outValid = (level_r != '0);
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem[rdPtr_r];
   assign level    = level_r;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         level_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= AW'(wrPtr_r + 1'b1);
         end
         if (pop) begin
            rdPtr_r <= AW'(rdPtr_r + 1'b1);
         end
         if (push && !pop) begin
            level_r <= LW'(level_r + 1'b1);
         end else if (pop && !push) begin
            level_r <= LW'(level_r - 1'b1);
         end
      end
   end
endmodule

// ### design/sac_adc_ctrl.sv
// conversion sequencing and parallel/serial readout of the converter
`timescale 1ns/1ns
// Summary of operation
// - sclk pin drives out with internal clock
// - invert input picks serial data change edge
// - parallel mode: marker/error pins carry bits 10,11
// - bits 12 to 15 always outputs
// - internal clock: marker active during valid data
// - marker polarity follows its polarity input
// - unfinished external read at completion flags error
// - busy high from start until result loaded
// - drivers enabled only with select and read low, except serial clock, marker and error pins
// - external clock ignored unless select low
// - reset pin high aborts conversion
// - power-down finishes current conversion, then halts
// - start high at acquisition end: await fall
// - start low at acquisition end: convert now
// - external clock: change rise, valid fall; swappable
// - internal clock: data stable on both edges
// - result shifts out msb first
// - read mode picks during or after conversion
module sac_adc_ctrl #(
   parameter int ACQ_TIME_NS  = 2000,
   parameter int CONV_TIME_NS = 8000
)(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  sac_pkg::sac_pins_t              pinsIn,
   input  wire logic [sac_pkg::DATA_W-1:0] resultIn,
   output logic                            holdOut,
   output logic                            busy,
   output logic                            powerDownState,
   output logic      [sac_pkg::DATA_W-1:0] dataOut,
   output logic      [sac_pkg::DATA_W-1:0] dataOe
);
   localparam int P        = sac_pkg::CLK_PERIOD_NS;
   localparam int ACQ_RAW  = (ACQ_TIME_NS + P - 1) / P;
   localparam int CONV_RAW = (CONV_TIME_NS + P - 1) / P;
   localparam int ACQ_CYC  = (ACQ_RAW < 1) ? 1 : ACQ_RAW;
   localparam int CONV_CYC = (CONV_RAW < 1) ? 1 : CONV_RAW;
   localparam int CW       = sac_pkg::CNT_W;
   localparam int DW       = sac_pkg::DATA_W;
   localparam int LW       = sac_pkg::LEVEL_W;
   localparam logic [CW-1:0] ACQ_LAST  = CW'(ACQ_CYC - 1);
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
   localparam logic [CW-1:0] QTR_LAST  = CW'(sac_pkg::SCLK_QTR_CYC - 1);

   sac_pkg::sac_pins_t  pins;
   sac_pkg::sac_state_t state_r;
   logic [CW-1:0]       cnt_r;
   logic                abort;
   logic                startPrev_r;
   logic                startFall;
   logic                csPrev_r;
   logic                sclkPrev_r;
   logic                busy_r;
   logic                convStart;
   logic                acqEnd;
   logic                intMode;
   logic                extMode;
   logic                rdEn;
   logic                fifoInReady;
   logic                fifoOutValid;
   logic [DW-1:0]       fifoOutData;
   logic [LW-1:0]       fifoLevel;
   logic                shiftReady;
   logic                pop;
   logic [DW-1:0]       result_r;
   logic [DW-1:0]       shift_r;
   logic [3:0]          bitCnt_r;
   logic                intActive_r;
   logic                extActive_r;
   logic                errPulse_r;
   logic [CW-1:0]       qCnt_r;
   logic                qEn;
   logic [1:0]          phase_r;
   logic                sclkInt;
   logic                sclkGated;
   logic                sclkRise;
   logic                sclkFall;
   logic                updEdge;
   logic                csFall;
   logic                frameLvl;
   logic [DW-1:0]       dataOut_nxt;
   logic [DW-1:0]       dataOut_r;

   sac_sync #(
      .W       (sac_pkg::PIN_W),
      .RST_VAL (sac_pkg::PIN_RST)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pinsIn),
      .q     (pins)
   );

   sac_fifo #(
      .W     (DW),
      .DEPTH (sac_pkg::FIFO_DEPTH),
      .LW    (LW)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n && !abort),
      .inValid  (state_r == sac_pkg::ST_LOAD),
      .inReady  (fifoInReady),
      .inData   (resultIn),
      .outValid (fifoOutValid),
      .outReady (shiftReady),
      .outData  (fifoOutData),
      .level    (fifoLevel)
   );

   assign abort     = pins.resetHi;
   assign startFall = startPrev_r && !pins.startN;
   assign acqEnd    = (state_r == sac_pkg::ST_ACQUIRE) && (cnt_r == ACQ_LAST);
   assign intMode   = pins.serSel && !pins.extClk;
   assign extMode   = pins.serSel && pins.extClk;
   assign rdEn      = !pins.csN && !pins.rdN;
   assign shiftReady = !(intMode && intActive_r);
   assign pop       = fifoOutValid && shiftReady;
   assign convStart = fifoInReady && !pins.powerDown &&
                      ((acqEnd && !pins.startN) ||
                       ((state_r == sac_pkg::ST_WAIT_START) && startFall));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         startPrev_r <= 1'b1;
         csPrev_r    <= 1'b1;
         sclkPrev_r  <= 1'b0;
      end else begin
         startPrev_r <= pins.startN;
         csPrev_r    <= pins.csN;
         sclkPrev_r  <= sclkGated;
      end
   end

   // conversion sequencer
   always_ff @(posedge clk) begin
      if (!rst_n || abort) begin
         state_r <= sac_pkg::ST_ACQUIRE;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            sac_pkg::ST_ACQUIRE: begin
               if (acqEnd) begin
                  cnt_r <= '0;
                  if (pins.powerDown) begin
                     state_r <= sac_pkg::ST_POWER_DOWN;
                  end else if (convStart) begin
                     state_r <= sac_pkg::ST_CONVERT;
                  end else begin
                     state_r <= sac_pkg::ST_WAIT_START;
                  end
               end else begin
                  cnt_r <= CW'(cnt_r + 1'b1);
               end
            end
            sac_pkg::ST_WAIT_START: begin
               if (pins.powerDown) begin
                  state_r <= sac_pkg::ST_POWER_DOWN;
               end else if (convStart) begin
                  state_r <= sac_pkg::ST_CONVERT;
               end
            end
            sac_pkg::ST_CONVERT: begin
               if (cnt_r == CONV_LAST) begin
                  cnt_r   <= '0;
                  state_r <= sac_pkg::ST_LOAD;
               end else begin
                  cnt_r <= CW'(cnt_r + 1'b1);
               end
            end
            sac_pkg::ST_LOAD: begin
               if (fifoInReady) begin
                  state_r <= sac_pkg::ST_ACQUIRE;
               end
            end
            sac_pkg::ST_POWER_DOWN: begin
               if (!pins.powerDown) begin
                  state_r <= sac_pkg::ST_ACQUIRE;
               end
            end
            default: begin
               state_r <= sac_pkg::ST_ACQUIRE;
               cnt_r   <= '0;
            end
         endcase
      end
   end

   // busy spans conversion until the shift register is loaded
   always_ff @(posedge clk) begin
      if (!rst_n || abort) begin
         busy_r <= 1'b0;
      end else if (convStart) begin
         busy_r <= 1'b1;
      end else if (pop && fifoLevel == LW'(1) &&
                   state_r != sac_pkg::ST_CONVERT &&
                   state_r != sac_pkg::ST_LOAD) begin
         busy_r <= 1'b0;
      end
   end

   // internal serial clock quarter-period divider
   always_ff @(posedge clk) begin
      if (!rst_n || !intActive_r) begin
         qCnt_r <= '0;
      end else if (qCnt_r == QTR_LAST) begin
         qCnt_r <= '0;
      end else begin
         qCnt_r <= CW'(qCnt_r + 1'b1);
      end
   end
   assign qEn = intActive_r && (qCnt_r == QTR_LAST);

   always_ff @(posedge clk) begin
      if (!rst_n || !intActive_r) begin
         phase_r <= '0;
      end else if (qEn) begin
         phase_r <= 2'(phase_r + 1'b1);
      end
   end
   // data changes mid-low, away from both edges
   assign sclkInt = (phase_r == sac_pkg::PH_RISE) ||
                    (phase_r == sac_pkg::PH_HIGH);

   // external clock seen only while selected
   assign sclkGated = pins.sclk && !pins.csN;
   assign sclkRise  = !pins.csN && sclkGated && !sclkPrev_r;
   assign sclkFall  = !pins.csN && !sclkGated && sclkPrev_r;
   assign updEdge   = pins.sclkInv ? sclkFall : sclkRise;
   assign csFall    = csPrev_r && !pins.csN;

   // result and shift register
   always_ff @(posedge clk) begin
      if (!rst_n || abort) begin
         result_r    <= '0;
         shift_r     <= '0;
         bitCnt_r    <= '0;
         intActive_r <= 1'b0;
         extActive_r <= 1'b0;
         errPulse_r  <= 1'b0;
      end else begin
         errPulse_r <= 1'b0;
         if (pop) begin
            result_r <= fifoOutData;
            shift_r  <= fifoOutData;
            bitCnt_r <= '0;
            if (extMode && extActive_r) begin
               extActive_r <= 1'b0;
               errPulse_r  <= 1'b1;
            end
            if (intMode && !pins.readMode) begin
               intActive_r <= 1'b1;
            end
         end else if (intMode && pins.readMode && convStart &&
                      !intActive_r) begin
            intActive_r <= 1'b1;
            shift_r     <= result_r;
            bitCnt_r    <= '0;
         end else if (intActive_r && qEn &&
                      phase_r == sac_pkg::PH_CHANGE) begin
            shift_r  <= {shift_r[DW-2:0], 1'b0};
            bitCnt_r <= 4'(bitCnt_r + 1'b1);
            if (bitCnt_r == sac_pkg::LAST_BIT) begin
               intActive_r <= 1'b0;
            end
         end else if (extMode && csFall) begin
            extActive_r <= 1'b1;
            bitCnt_r    <= '0;
         end else if (extMode && extActive_r && updEdge) begin
            shift_r  <= {shift_r[DW-2:0], pins.readMode};
            bitCnt_r <= 4'(bitCnt_r + 1'b1);
            if (bitCnt_r == sac_pkg::LAST_BIT) begin
               extActive_r <= 1'b0;
            end
         end
         if (!intMode) begin
            intActive_r <= 1'b0;
         end
      end
   end

   assign frameLvl = pins.framePol ? !intActive_r : intActive_r;

   // pin multiplexing between parallel and serial use
   always_comb begin
      dataOut_nxt = result_r;
      dataOe      = {DW{rdEn}};
      if (pins.serSel) begin
         dataOut_nxt                 = '0;
         dataOe                      = '0;
         dataOut_nxt[sac_pkg::SERIAL_DATA_OUT_BIT] = shift_r[DW-1];
         dataOe[sac_pkg::SERIAL_DATA_OUT_BIT]  = rdEn;
         dataOut_nxt[sac_pkg::SCLK_BIT]  = sclkInt ^ pins.sclkInv;
         dataOe[sac_pkg::SCLK_BIT]   = !pins.extClk;
         dataOut_nxt[sac_pkg::FRAME_BIT] = frameLvl;
         dataOe[sac_pkg::FRAME_BIT]  = 1'b1;
         dataOut_nxt[sac_pkg::ERR_BIT]   = errPulse_r;
         dataOe[sac_pkg::ERR_BIT]    = 1'b1;
         dataOut_nxt[DW-1:sac_pkg::UPPER_LSB] =
            result_r[DW-1:sac_pkg::UPPER_LSB];
         dataOe[DW-1:sac_pkg::UPPER_LSB] = {(DW-sac_pkg::UPPER_LSB){rdEn}};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dataOut_r <= '0;
      end else begin
         dataOut_r <= dataOut_nxt;
      end
   end

   assign dataOut        = dataOut_r;
   assign busy           = busy_r;
   assign holdOut        = (state_r == sac_pkg::ST_CONVERT);
   assign powerDownState = (state_r == sac_pkg::ST_POWER_DOWN);

   property p_sclkDir;
      @(posedge clk) disable iff (!rst_n)
      pins.serSel |-> (dataOe[sac_pkg::SCLK_BIT] == !pins.extClk);
   endproperty
   a_sclkDir: assert property (p_sclkDir)
      else $error("serial clock direction wrong");

   property p_parBits;
      @(posedge clk) disable iff (!rst_n)
      !pins.serSel ##1 !pins.serSel |->
         dataOut[sac_pkg::ERR_BIT:sac_pkg::FRAME_BIT] ==
         $past(result_r[sac_pkg::ERR_BIT:sac_pkg::FRAME_BIT]);
   endproperty
   a_parBits: assert property (p_parBits)
      else $error("parallel bits 10/11 wrong");

   property p_upperOut;
      @(posedge clk) disable iff (!rst_n)
      rdEn |-> (&dataOe[DW-1:sac_pkg::UPPER_LSB]);
   endproperty
   a_upperOut: assert property (p_upperOut)
      else $error("upper data bits not driven");

   property p_rdGate;
      @(posedge clk) disable iff (!rst_n)
      dataOe[sac_pkg::SERIAL_DATA_OUT_BIT] |-> rdEn;
   endproperty
   a_rdGate: assert property (p_rdGate)
      else $error("output enabled without select and read");

   property p_rdErr;
      @(posedge clk) disable iff (!rst_n || abort)
      (extMode && extActive_r && pop) |=> errPulse_r ##1 !errPulse_r;
   endproperty
   a_rdErr: assert property (p_rdErr)
      else $error("read error pulse missing");

   property p_busyConv;
      @(posedge clk) disable iff (!rst_n)
      (state_r == sac_pkg::ST_CONVERT || state_r == sac_pkg::ST_LOAD)
         |-> busy_r;
   endproperty
   a_busyConv: assert property (p_busyConv)
      else $error("busy low during conversion");

   property p_abort;
      @(posedge clk) disable iff (!rst_n)
      abort |=> (state_r == sac_pkg::ST_ACQUIRE) && !busy_r && !holdOut;
   endproperty
   a_abort: assert property (p_abort)
      else $error("reset did not abort");

   property p_pwrDown;
      @(posedge clk) disable iff (!rst_n || abort)
      (state_r == sac_pkg::ST_WAIT_START && pins.powerDown) |=>
         powerDownState;
   endproperty
   a_pwrDown: assert property (p_pwrDown)
      else $error("power-down not entered");

   property p_waitEdge;
      @(posedge clk) disable iff (!rst_n || abort)
      (state_r == sac_pkg::ST_WAIT_START && !startFall) |=> !holdOut;
   endproperty
   a_waitEdge: assert property (p_waitEdge)
      else $error("conversion without start edge");

   property p_startNow;
      @(posedge clk) disable iff (!rst_n || abort)
      (acqEnd && !pins.startN && fifoInReady && !pins.powerDown) |=>
         holdOut && busy_r;
   endproperty
   a_startNow: assert property (p_startNow)
      else $error("immediate start missed");

   property p_frame;
      @(posedge clk) disable iff (!rst_n)
      intMode |-> (dataOut_nxt[sac_pkg::FRAME_BIT] ==
                   (intActive_r ^ pins.framePol));
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame marker level wrong");
endmodule

// ### sim/sac_host.sv
// host model: parallel reader and external-clock serial reader
`timescale 1ns/1ns
module sac_host (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [4:0]  nBits,
   input  wire logic        inv,
   input  wire logic [15:0] bus,
   output logic             csN,
   output logic             rdN,
   output logic             sclk,
   output logic      [15:0] word,
   output logic             done
);
   initial begin
      csN = 1'b1;
      rdN = 1'b1;
      sclk = 1'b0;
      word = '0;
      done = 1'b0;
      forever begin
         @(posedge clk);
         done <= 1'b0;
         sclk <= inv;
         if (go) begin
            csN <= 1'b1;
            rdN <= 1'b1;
            repeat (8) @(posedge clk);
            csN <= 1'b0;
            rdN <= 1'b0;
            repeat (16) @(posedge clk);
            for (int i = 0; i < nBits; i++) begin
               word <= {word[14:0], bus[sac_pkg::SERIAL_DATA_OUT_BIT]};
               sclk <= ~inv;
               repeat (8) @(posedge clk);
               sclk <= inv;
               repeat (8) @(posedge clk);
            end
            // partial reads keep the select low
            if (nBits == 5'h0)
               word <= bus;
            if (nBits == 5'h0 || nBits == 5'h10) begin
               csN <= 1'b1;
               rdN <= 1'b1;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// ### sim/tb.sv
// self-checking bench of the converter control
`timescale 1ns/1ns
`define CHK(n, g, e) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("unexpected %s: expected %h seen %h", n, e, g); \
   end \
end
module tb;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   sac_pkg::sac_pins_t p = sac_pkg::PIN_RST;
   sac_pkg::sac_pins_t pinsW;
   logic [15:0]        res = '0;
   logic               holdOut, busy, pdState;
   logic [15:0]        dataOut, dataOe;
   logic [15:0]        busW;
   logic               go = 1'b0;
   logic [4:0]         nBits = '0;
   logic               hCs, hRd, hSclk, hDone;
   logic [15:0]        hWord, expW;
   logic [15:0]        inW = '0;
   logic [4:0]         inCnt = '0;
   logic               mPrev = 1'b0;
   logic               s9 = 1'b0;
   logic               mAct, fEnd;
   logic [31:0]        seed = 32'h0000_004e;
   int                 errCnt = 0;
   int                 failures = 0;
   int                 n_tests = 0;
   logic [15:0]        expQ[$];

   always #2 clk = ~clk;

   always_comb begin
      pinsW = p;
      // internal-clock reads need select and read held low
      pinsW.csN = hCs & ~(p.serSel & ~p.extClk);
      pinsW.rdN = hRd & ~(p.serSel & ~p.extClk);
      pinsW.sclk = dataOe[9] ? dataOut[9] : hSclk;
   end

   // a released pin reads back as the inverse of the last value
   assign busW = ~(dataOut ^ dataOe);

   sac_adc_ctrl #(.ACQ_TIME_NS(40), .CONV_TIME_NS(80)) sac_adc_ctrl_inst (
      .clk(clk), .rst_n(rst_n), .pinsIn(pinsW), .resultIn(res),
      .holdOut(holdOut), .busy(busy), .powerDownState(pdState),
      .dataOut(dataOut), .dataOe(dataOe));

   sac_host sac_host_inst (
      .clk(clk), .go(go), .nBits(nBits), .inv(p.sclkInv), .bus(busW),
      .csN(hCs), .rdN(hRd), .sclk(hSclk), .word(hWord), .done(hDone));

   // frame marker active level follows its polarity input
   assign mAct = p.serSel & ~p.extClk & (busW[10] ^ p.framePol);
   assign fEnd = mPrev & ~mAct & (inCnt != 5'h0);

   always @(posedge clk) begin
      s9 <= busW[9];
      mPrev <= mAct;
      if (mAct & busW[9] & ~s9) begin
         inW <= {inW[14:0], busW[8]};
         inCnt <= inCnt + 5'h1;
      end
      if (fEnd) begin
         `CHK("bits", inCnt, 5'h10)
         inCnt <= '0;
      end
      if (hDone | fEnd) begin
         expW = expQ.pop_front();
         `CHK("word", hDone ? hWord : inW, expW)
      end
      if (p.serSel & p.extClk & dataOut[11])
         errCnt <= errCnt + 1;
   end

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic waitBusy(input logic v);
      int k;
      k = 0;
      while (busy !== v && k < 700) begin
         @(posedge clk);
         k++;
      end
      `CHK("busy", busy, v)
   endtask

   task automatic convert(input logic [15:0] r);
      repeat (20) @(posedge clk);
      res <= r;
      p.startN <= 1'b0;
      waitBusy(1'b1);
      repeat (18) @(posedge clk);
      `CHK("hold", holdOut, 1'b1)
      `CHK("busy", busy, 1'b1)
      p.startN <= 1'b1;
      waitBusy(1'b0);
   endtask

   task automatic rd(input logic [4:0] n);
      int k;
      k = 0;
      go <= 1'b1;
      nBits <= n;
      @(posedge clk);
      go <= 1'b0;
      repeat (20) @(posedge clk);
      if (!p.serSel) `CHK("oe", dataOe, 16'hffff)
      while ((n == 5'h0 || n[4]) && hDone !== 1'b1 && k < 600) begin
         @(posedge clk);
         k++;
      end
      `CHK("read", k < 600, 1'b1)
      repeat (10) @(posedge clk);
      if (!p.serSel) `CHK("oe", dataOe, 16'h0000)
   endtask

   initial begin
      logic [15:0] r;
      int base;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      r = rnd();
      convert(r);
      expQ.push_back(r);
      rd(5'h0);
      expQ.push_back(r);
      rd(5'h0);
      r = rnd();
      res <= r;
      p.startN <= 1'b0;
      waitBusy(1'b1);
      waitBusy(1'b0);
      waitBusy(1'b1);
      p.startN <= 1'b1;
      waitBusy(1'b0);
      expQ.push_back(r);
      rd(5'h0);
      for (int i = 0; i < 2; i++) begin
         p.serSel <= 1'b1;
         p.extClk <= 1'b1;
         p.sclkInv <= i[0];
         repeat (10) @(posedge clk);
         `CHK("sclk oe", dataOe[9], 1'b0)
         r = rnd();
         convert(r);
         expQ.push_back(r);
         rd(5'h10);
      end
      convert(rnd());
      rd(5'h4);
      repeat (70) @(posedge clk);
      base = errCnt;
      r = rnd();
      convert(r);
      repeat (10) @(posedge clk);
      `CHK("err", errCnt - base, 1)
      expQ.push_back(r);
      rd(5'h10);
      p.extClk <= 1'b0;
      p.sclkInv <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         p.framePol <= i[0];
         r = rnd();
         convert(r);
         expQ.push_back(r);
         `CHK("sclk oe", dataOe[9], 1'b1)
         repeat (300) @(posedge clk);
      end
      p.readMode <= 1'b1;
      expQ.push_back(r);
      r = rnd();
      convert(r);
      p.readMode <= 1'b0;
      p.serSel <= 1'b0;
      expQ.push_back(r);
      rd(5'h0);
      p.startN <= 1'b0;
      waitBusy(1'b1);
      p.resetHi <= 1'b1;
      p.startN <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("busy", busy, 1'b0)
      `CHK("hold", holdOut, 1'b0)
      p.resetHi <= 1'b0;
      repeat (20) @(posedge clk);
      expQ.push_back(16'h0000);
      rd(5'h0);
      repeat (20) @(posedge clk);
      p.startN <= 1'b0;
      waitBusy(1'b1);
      p.powerDown <= 1'b1;
      p.startN <= 1'b1;
      waitBusy(1'b0);
      repeat (20) @(posedge clk);
      `CHK("pd", pdState, 1'b1)
      p.startN <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK("busy", busy, 1'b0)
      `CHK("queue", expQ.size(), 0)
      print_verdict();
   end

   initial begin
      #100000;
      failures++;
      print_verdict();
   end
endmodule
